// *** stn_link_chk.sv ***
// assertions on the wires between controller and panel
`timescale 1ns/1ps
module stn_link_chk (
    // clock and reset
    input wire logic                        clk,
    input wire logic                        sys_rst,
    // link
    input wire logic                        shift_clock,
    input wire logic                        row_latch_pulse,
    input wire logic                        frame_scan_start,
    input wire logic                        frame_polarity,
    input wire logic [stn_pkg::DATA_W-1:0]  pixel_data_bus
);
    import stn_pkg::*;
    logic [7:0] sc_cnt_reg;
    logic       sc_d_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // shift clock rises since the last latch pulse
    always_ff @(posedge clk) begin
        sc_d_reg <= shift_clock;
        if (sys_rst || row_latch_pulse)
            sc_cnt_reg <= 8'h00;
        else if (shift_clock && !sc_d_reg)
            sc_cnt_reg <= sc_cnt_reg + 8'h01;
    end
    chk_row_byte_count: assert property (
        $rose(row_latch_pulse) |-> sc_cnt_reg == 8'(CLKS_PER_ROW))
        else $error("shift count per row wrong");
    chk_latch_width: assert property (
        $rose(row_latch_pulse) |-> ##39 row_latch_pulse ##1 !row_latch_pulse)
        else $error("latch pulse width wrong");
    chk_shift_high: assert property (
        $rose(shift_clock) |-> ##9 shift_clock ##1 !shift_clock)
        else $error("shift clock high time wrong");
    chk_data_hold: assert property (
        shift_clock && $past(shift_clock) |-> $stable(pixel_data_bus))
        else $error("data moved while shift clock high");
    chk_no_shift_latch: assert property (
        $fell(row_latch_pulse) |-> !shift_clock [*8])
        else $error("shift clock too close to latch");
    chk_start_stable: assert property (
        $fell(row_latch_pulse) |-> $stable(frame_scan_start))
        else $error("frame start moved at latch");
    chk_pol_toggle: assert property (
        $fell(row_latch_pulse) && frame_scan_start
        |-> ##[0:10] $changed(frame_polarity))
        else $error("polarity did not toggle at frame start");
    chk_reset_idle: assert property (
        $past(sys_rst) |-> !shift_clock && !row_latch_pulse && !frame_polarity)
        else $error("link not idle after reset");
endmodule

// *** stn_link_if.sv ***
// link wires between panel controller and panel input logic
`timescale 1ns/1ps
interface stn_link_if;
    import stn_pkg::*;
    logic              shift_clock;
    logic              row_latch_pulse;
    logic              frame_scan_start;
    logic              frame_polarity;
    logic [DATA_W-1:0] pixel_data_bus;
    modport ctrl  (output shift_clock, output row_latch_pulse,
                   output frame_scan_start, output frame_polarity,
                   output pixel_data_bus);
    modport panel (input shift_clock, input row_latch_pulse,
                   input frame_scan_start, input frame_polarity,
                   input pixel_data_bus);
endinterface

// *** stn_panel_ctrl.sv ***
// controller end: generates pixel stream and timing pulses
`timescale 1ns/1ps
module stn_panel_ctrl (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // user pixel source
    input  wire logic [stn_pkg::DATA_W-1:0] pix_data,
    output logic                       pix_req,
    // link
    stn_link_if.ctrl                   link
);
    import stn_pkg::*;

    typedef enum logic [1:0] {SHIFT_LO, SHIFT_HI, LATCH_HI, LATCH_LO} st_e;

    st_e               state_reg;
    logic [7:0]        tmr_reg;
    logic [CNT_W-1:0]  cnt_reg;
    logic [ROW_W-1:0]  row_reg;
    logic              sck_reg, lp_reg, yd_reg, pol_reg, req_reg;
    logic [DATA_W-1:0] dat_reg;

    wire tmr_done  = (tmr_reg == 8'h00);
    wire last_clk  = (cnt_reg == CNT_W'(CLKS_PER_ROW - 1));
    wire last_row  = (row_reg == ROW_W'(NUM_ROWS - 1));

    // ************************************************************
    // link sequencer
    // ************************************************************
    always_ff @(posedge clk) begin
        req_reg <= 1'b0;
        if (sys_rst) begin
            state_reg <= SHIFT_LO;
            tmr_reg   <= 8'(SHIFT_HALF_CYC - 1);
            cnt_reg   <= '0;
            row_reg   <= '0;
            sck_reg   <= 1'b0;
            lp_reg    <= 1'b0;
            yd_reg    <= 1'b0;
            pol_reg   <= 1'b0;
            dat_reg   <= '0;
        end else if (!tmr_done) begin
            tmr_reg <= tmr_reg - 8'h01;
        end else begin
            case (state_reg)
                SHIFT_LO: begin
                    dat_reg   <= pix_data;
                    req_reg   <= 1'b1;
                    sck_reg   <= 1'b1;
                    tmr_reg   <= 8'(SHIFT_HALF_CYC - 1);
                    state_reg <= SHIFT_HI;
                end
                SHIFT_HI: begin
                    sck_reg <= 1'b0;
                    tmr_reg <= 8'(SHIFT_HALF_CYC - 1);
                    if (last_clk) begin
                        cnt_reg   <= '0;
                        state_reg <= LATCH_HI;
                    end else begin
                        cnt_reg   <= cnt_reg + CNT_W'(1);
                        state_reg <= SHIFT_LO;
                    end
                end
                LATCH_HI: begin
                    lp_reg    <= 1'b1;
                    yd_reg    <= (row_reg == '0);
                    tmr_reg   <= 8'(LATCH_HIGH_CYC - 1);
                    state_reg <= LATCH_LO;
                end
                LATCH_LO: begin
                    lp_reg  <= 1'b0;
                    tmr_reg <= 8'(LATCH_HIGH_CYC - 1);
                    if (row_reg == '0)
                        pol_reg <= ~pol_reg;
                    row_reg   <= last_row ? '0 : row_reg + ROW_W'(1);
                    state_reg <= SHIFT_LO;
                end
                default: state_reg <= SHIFT_LO;
            endcase
        end
    end

    // yd held low again at next row latch
    assign link.shift_clock      = sck_reg;
    assign link.row_latch_pulse  = lp_reg;
    assign link.frame_scan_start = yd_reg;
    assign link.frame_polarity   = pol_reg;
    assign link.pixel_data_bus   = dat_reg;
    assign pix_req               = req_reg;
endmodule

// *** stn_panel_input.sv ***
// panel end: column drivers, row latch and scan logic
`timescale 1ns/1ps
// Overview of operation
// - each driver: 240-bit shift, latch, outputs
// - eight bits per shift clock, left first
// - controller drives eight data lines
// - row latched on latch pulse falling edge
// - next row shifts while current shown
// - 240 rows per frame, then wrap
// - frame start coincides with first latch
// - polarity toggles once per frame
// - select passes right every 30 clocks
// - only selected driver takes data
// - controller streams continuously, no frame store
// - latch pulses at equal intervals
// - one-in-240 duty single scan line
module stn_panel_input #(
    parameter int NDRV = stn_pkg::NUM_DRIVERS
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    // link
    stn_link_if.panel                         link,
    // column electrode drive
    output logic [stn_pkg::ROW_BITS-1:0]      column_drive,
    output logic                              drive_polarity,
    // row scan electrode select
    output logic [stn_pkg::NUM_ROWS-1:0]      row_scan_driver
);
    import stn_pkg::*;

    // width of the resampled control pin group
    localparam int SYNC_W = 4;
    // width of the per-driver shift clock counter
    localparam int SUB_W  = $clog2(CLKS_PER_DRV);
    // bit positions of the control pins in the resampled group:
    // shift clock, latch pulse, frame start, polarity
    localparam int PIN_SCK = 0;
    localparam int PIN_LP  = 1;
    localparam int PIN_YD  = 2;
    localparam int PIN_POL = 3;

    // ************************************************************
    // pin synchronisers and edge detection
    // ************************************************************
    // the link arrives from another chip, so every pin is resampled
    // twice before any logic reads it; the third control stage only
    // feeds the edge detectors. data and control pass the same depth,
    // so the byte in d2 is the one that stood on the bus when the
    // shift clock edge was seen. a multi-bit bus sampled this way is
    // only safe because the controller holds it for many clock cycles
    // after each shift clock rise; it changes in the same cycle as the rise.
    logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg;
    logic [DATA_W-1:0] d1_reg, d2_reg;
    wire  [SYNC_W-1:0] pin_raw;

    // control pins gathered in their fixed order; one bit per pin so
    // a new pin needs a position, a line here and a larger SYNC_W
    assign pin_raw[PIN_SCK] = link.shift_clock;
    assign pin_raw[PIN_LP]  = link.row_latch_pulse;
    assign pin_raw[PIN_YD]  = link.frame_scan_start;
    assign pin_raw[PIN_POL] = link.frame_polarity;

    // control stages start at the idle low level of the pins, so no
    // false edge can be seen in the first cycles after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // data stages need no reset: bytes are only taken on a clock edge
    always_ff @(posedge clk) begin
        d1_reg <= link.pixel_data_bus;
        d2_reg <= d1_reg;
    end

    // edges and levels of the resampled control pins. a pin change
    // is acted on three clock cycles after it appears, and all pins
    // share that delay, so their relative order is kept.
    wire sck_rise = s2_reg[PIN_SCK] & ~s3_reg[PIN_SCK];
    wire lp_fall  = ~s2_reg[PIN_LP] & s3_reg[PIN_LP];
    wire yd_now   = s2_reg[PIN_YD];
    wire pol_now  = s2_reg[PIN_POL];

    // ************************************************************
    // chip select ripple
    // ************************************************************
    // one counter of shift clocks per driver and one select index;
    // both restart on every latch so a row always begins at the
    // leftmost driver, even after a short or cut row. surplus clocks
    // beyond a full row stay on the rightmost driver and shift it.
    logic [DRV_W-1:0] sel_reg;
    logic [SUB_W-1:0] sub_reg;
    wire              sub_last;
    wire              sel_last;
    wire [DRV_W-1:0]  sel_next;
    wire [SUB_W-1:0]  sub_next;

    // next select and counter values
    assign sub_last = (sub_reg == SUB_W'(CLKS_PER_DRV - 1));
    // sel_last keeps the index from running past the last driver
    assign sel_last = (sel_reg == DRV_W'(NDRV - 1));
    assign sel_next = (sub_last && !sel_last) ? sel_reg + DRV_W'(1)
                                              : sel_reg;
    // counter wraps after the last clock of a driver
    assign sub_next = sub_last ? '0 : sub_reg + SUB_W'(1);

    always_ff @(posedge clk) begin
        if (sys_rst || lp_fall) begin
            sel_reg <= '0;
            sub_reg <= '0;
        end else if (sck_rise) begin
            sel_reg <= sel_next;
            sub_reg <= sub_next;
        end
    end

    // ************************************************************
    // column drivers
    // ************************************************************
    // each driver keeps its own shift register and latch. the shift
    // registers carry no reset: a full row rewrites every byte before
    // the next latch, so whatever they held at power-up never reaches
    // the column outputs. the latches are reset so the panel shows a
    // blank row until the first latch pulse ends.
    // byte k of a row lands in driver k/30; the first byte of a
    // driver ends in its top eight bits, bit 7 being leftmost.
    wire [ROW_BITS-1:0] latch_all;

    genvar g;
    generate
        for (g = 0; g < NDRV; g++) begin : drv
            logic [DRIVER_BITS-1:0] shift_reg;
            logic [DRIVER_BITS-1:0] latch_reg;
            wire                    en;
            wire [DRIVER_BITS-1:0]  shift_next;
            assign en = sck_rise && (sel_reg == DRV_W'(g));
            assign shift_next = {shift_reg[DRIVER_BITS-DATA_W-1:0],
                                 d2_reg};
            always_ff @(posedge clk) begin
                if (en)
                    shift_reg <= shift_next;
            end
            always_ff @(posedge clk) begin
                if (sys_rst)
                    latch_reg <= '0;
                else if (lp_fall)
                    latch_reg <= shift_reg;
            end
            // leftmost driver in top bits
            assign latch_all[ROW_BITS-1-g*DRIVER_BITS -: DRIVER_BITS] =
                latch_reg;
        end
    endgenerate

    // one register stage drives all column outputs together; they
    // change only here, one cycle after the latches
    always_ff @(posedge clk) begin
        column_drive <= latch_all;
    end

    // ************************************************************
    // row scan
    // ************************************************************
    // the scan line is one-hot and moves by one on each latch. the
    // frame start level, seen when the latch pulse ends, puts the
    // line back on the top row; without it the line wraps from the
    // bottom row to the top by itself. polarity is taken at the same
    // instant so the drive inverts exactly at the frame boundary.
    // until the first frame start no scan line is active, so a
    // half-loaded first frame never shows.
    wire [NUM_ROWS-1:0] scan_top;
    wire [NUM_ROWS-1:0] scan_rot;
    wire [NUM_ROWS-1:0] scan_next;

    assign scan_top  = NUM_ROWS'(1);
    assign scan_rot  = {row_scan_driver[NUM_ROWS-2:0],
                        row_scan_driver[NUM_ROWS-1]};
    assign scan_next = yd_now ? scan_top : scan_rot;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            row_scan_driver <= '0;
            drive_polarity  <= 1'b0;
        end else if (lp_fall) begin
            row_scan_driver <= scan_next;
            drive_polarity  <= pol_now;
        end
    end
endmodule

// *** stn_pkg.sv ***
// shared constants for the passive-matrix panel row input link
package stn_pkg;
    localparam int DATA_W        = 8;    // pixel_data_bus width
    localparam int DRIVER_BITS   = 240;  // bits per column driver chip
    localparam int NUM_DRIVERS   = 4;    // 960 sub-pixels / 240
    localparam int ROW_BITS      = DRIVER_BITS * NUM_DRIVERS;
    localparam int CLKS_PER_DRV  = DRIVER_BITS / DATA_W;   // 30
    localparam int CLKS_PER_ROW  = ROW_BITS / DATA_W;      // 120
    localparam int NUM_ROWS      = 240;
    localparam int ROW_W         = 8;    // row counter width
    localparam int CNT_W         = 7;    // shift counter width
    localparam int DRV_W         = 2;    // driver select width
    localparam int CLK_MHZ       = 200;
    // shift clock half period, latch pulse width (ns)
    localparam int SHIFT_HALF_NS = 50;
    localparam int LATCH_HIGH_NS = 200;
    localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int LATCH_HIGH_CYC = (LATCH_HIGH_NS * CLK_MHZ + 999) / 1000;
endpackage

// *** test_stn_panel_row_data_input.sv ***
// testbench joining controller and panel ends over the link
`timescale 1ns/1ps
module test_stn_panel_row_data_input;
    import stn_pkg::*;
    logic                clk;
    logic                sys_rst;
    logic [DATA_W-1:0]   pix_data;
    logic                pix_req;
    logic [ROW_BITS-1:0] column_drive;
    logic                drive_polarity;
    logic [NUM_ROWS-1:0] row_scan_driver;
    int                  num_errors = 0;
    int                  num_checks = 0;
    int                  nbytes = 0;
    // latch fall to latch fall, from the link timing constants (ns)
    localparam int ROW_NS = (2 * SHIFT_HALF_CYC * CLKS_PER_ROW
                             + 2 * LATCH_HIGH_CYC) * 1000 / CLK_MHZ;
    stn_link_if link ();
    stn_panel_ctrl u_stn_panel_ctrl (.clk(clk), .sys_rst(sys_rst),
        .pix_data(pix_data), .pix_req(pix_req), .link(link));
    stn_panel_input u_stn_panel_input (.clk(clk), .sys_rst(sys_rst),
        .link(link), .column_drive(column_drive),
        .drive_polarity(drive_polarity), .row_scan_driver(row_scan_driver));
    stn_link_chk u_stn_link_chk (.clk(clk), .sys_rst(sys_rst),
        .shift_clock(link.shift_clock), .row_latch_pulse(link.row_latch_pulse),
        .frame_scan_start(link.frame_scan_start),
        .frame_polarity(link.frame_polarity),
        .pixel_data_bus(link.pixel_data_bus));
    // ************
    // helpers
    // ************
    function automatic logic [7:0] pat(input int n);
        return 8'(n % 120) ^ 8'(n / 120 * 53);
    endfunction
    task automatic compare(input logic [ROW_BITS-1:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ************
    // stimulus
    // ************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // next byte of the stream once the current one is taken
    always @(posedge clk) begin
        if (!sys_rst && pix_req) begin
            nbytes <= nbytes + 1;
            pix_data <= pat(nbytes + 1);
        end
    end
    initial begin
        logic [ROW_BITS-1:0] exp;
        time                 t[3];
        sys_rst = 1'b1;
        pix_data = pat(0);
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        for (int r = 0; r < 3; r++) begin
            @(negedge link.row_latch_pulse);
            t[r] = $time;
            repeat (6) @(posedge clk);
            #1;
            for (int k = 0; k < CLKS_PER_ROW; k++)
                exp[ROW_BITS-1-8*k -: 8] = pat(r * 120 + k);
            compare(column_drive, exp);
            compare(ROW_BITS'(row_scan_driver), ROW_BITS'(1) << r);
            compare(ROW_BITS'(link.frame_polarity), ROW_BITS'(1));
            compare(ROW_BITS'(drive_polarity), ROW_BITS'(1));
        end
        compare(ROW_BITS'(t[2] - t[1]), ROW_BITS'(t[1] - t[0]));
        compare(ROW_BITS'(t[1] - t[0]), ROW_BITS'(ROW_NS));
        report_and_stop();
    end
    // hang guard, about 2.7 times the three-row run
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
endmodule
